// ---- rx_sync_tx_config_regs_test.sv ----
`timescale 1ns/1ns
module rx_sync_tx_config_regs_test;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       rx_data_pin = 1'b0;
  logic       rx_strobe_raw = 1'b0;
  logic       continuous_mode = 1'b0;
  logic       buffered_mode = 1'b0;
  logic       fill_manual = 1'b0;
  logic       sync_restart = 1'b0;
  logic [7:0] rssi_meas = 8'h00;
  logic [1:0] ook_mode = 2'h0;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, ook_threshold;
  logic       cfg_wr, cfg_rd, rx_data_out, rx_data_strobe, sync_match, sync_found;
  logic       fifo_fill_start, tx_zero_if, tx_deviation_en;
  logic [3:0] tx_smoothing_cutoff;
  logic [2:0] tx_power_step;
  int         err_total = 0;
  int         n_tests = 0;
  int         m_cnt = 0;
  int         f_cnt = 0;
  always #2 clk = ~clk;
  rxcfg_regs #(.BIT_CYCLES(8), .CHIP_CYCLES(16)) rxcfg_regs_inst (.clk, .reset_n, .cfg_addr,
    .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .rx_data_pin, .rx_strobe_raw, .continuous_mode,
    .buffered_mode, .fill_manual, .sync_restart, .rssi_meas, .ook_mode, .rx_data_out,
    .rx_data_strobe, .sync_match, .sync_found, .fifo_fill_start, .ook_threshold,
    .tx_smoothing_cutoff, .tx_power_step, .tx_zero_if, .tx_deviation_en);
  rxcfg_host rxcfg_host_inst (.clk, .cfg_rdata, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata);
  always @(posedge clk) begin
    if (sync_match === 1'b1) m_cnt <= m_cnt + 1;
    if (fifo_fill_start === 1'b1) f_cnt <= f_cnt + 1;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rxcfg_host_inst.rd(a, d);
    chk(d, exp);
  endtask
  function automatic logic [7:0] dflt(input logic [7:0] a);
    case (a)
      8'h12: return 8'h18;
      8'h13: return 8'h04;
      8'h1A: return 8'h72;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] step_of(input logic [2:0] c);
    return (c < 3'h4) ? 8'(c) + 8'h01 : 8'(c) * 8'h02 - 8'h02;
  endfunction
  // Cycles between decrements with a 16 cycle chip
  function automatic int per_of(input logic [2:0] r);
    return r[2] ? 16 >> (int'(r[1:0]) + 1) : 16 << int'(r[1:0]);
  endfunction
  task automatic wait_thr(input logic [7:0] v, input logic eq);
    for (int i = 0; i < 400; i++) begin
      #1;
      if ((ook_threshold === v) == eq) return;
      @(posedge clk);
    end
    err_total++;
    print_verdict;
  endtask
  // Sends the top pattern bits with nf low bits flipped
  task automatic sync_case(input logic [1:0] sz, input logic [1:0] tol, input int nf,
                           input logic bs);
    logic [31:0] pat;
    logic [31:0] tx;
    logic        hit;
    int          len;
    int          m0;
    int          f0;
    pat = $urandom;
    len = 8 * (int'(sz) + 1);
    tx = pat ^ (((32'h1 << nf) - 32'h1) << (32 - len));
    hit = (nf <= int'(tol));
    for (int i = 0; i < 4; i++) rxcfg_host_inst.wr(8'(8'h16 + i), pat[31 - 8 * i -: 8]);
    rxcfg_host_inst.wr(8'h12, {1'b0, ~bs, 1'b0, sz, tol, 1'b0});
    rxcfg_host_inst.wr(8'h12, {1'b0, ~bs, 1'b1, sz, tol, 1'b0});
    @(posedge clk);
    buffered_mode <= 1'($urandom);
    fill_manual <= 1'($urandom);
    m0 = m_cnt;
    f0 = f_cnt;
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      rx_data_pin <= tx[31 - i];
      repeat (bs ? 6 : 3) @(posedge clk);
      rx_strobe_raw <= ~bs;
      @(posedge clk);
      rx_strobe_raw <= 1'b0;
      #1;
      if (!bs) chk({6'h00, rx_data_strobe, rx_data_out}, {6'h00, 1'b1, tx[31 - i]});
    end
    repeat (10) @(posedge clk);
    #1;
    chk(8'(m_cnt - m0), {7'h00, hit});
    chk(8'(f_cnt - f0), {7'h00, hit & buffered_mode & ~fill_manual});
    chk({7'h00, sync_found}, {7'h00, hit});
    @(posedge clk);
    sync_restart <= 1'b1;
    @(posedge clk);
    sync_restart <= 1'b0;
    @(posedge clk);
    #1;
    chk({7'h00, sync_found}, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] f;
    logic [2:0] c;
    logic [2:0] r;
    logic [7:0] v;
    int         n;
    void'($urandom(19747));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    for (a = 8'h11; a <= 8'h1B; a++) rchk(a, dflt(a));
    @(posedge clk);
    rssi_meas <= 8'($urandom);
    for (a = 8'h12; a <= 8'h1A; a++) begin
      d = 8'($urandom);
      if (a == 8'h15) d[1:0] = {2{d[0]}};
      rxcfg_host_inst.wr(a, d);
      rchk(a, (a == 8'h14) ? rssi_meas : d);
    end
    chk({tx_smoothing_cutoff, tx_power_step, tx_zero_if}, d);
    chk({7'h00, tx_deviation_en}, {7'h00, ~d[0]});
    for (int k = 0; k < 8; k++) begin
      rxcfg_host_inst.wr(8'h1A, {4'h7, 3'(k), 1'b1});
      chk({5'h00, tx_power_step}, 8'(k));
    end
    f = 8'($urandom_range(128));
    rxcfg_host_inst.wr(8'h13, f);
    @(posedge clk);
    ook_mode <= rxcfg_pkg::OOK_MODE_PEAK;
    for (int k = 0; k < 8; k++) begin
      r = 3'(7 - k);
      rxcfg_host_inst.wr(8'h15, {3'(k), r, 2'h0});
      @(posedge clk);
      rssi_meas <= 8'hC8;
      wait_thr(8'hC8, 1'b1);
      @(posedge clk);
      rssi_meas <= 8'h00;
      wait_thr(8'hC8, 1'b0);
      chk(ook_threshold, 8'hC8 - step_of(3'(k)));
      v = ook_threshold;
      n = 0;
      while (ook_threshold === v && n < 200) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(8'(n), 8'(per_of(r)));
    end
    rxcfg_host_inst.wr(8'h15, 8'hFC);
    wait_thr(f, 1'b1);
    repeat (4) @(posedge clk);
    #1;
    chk(ook_threshold, f);
    @(posedge clk);
    ook_mode <= rxcfg_pkg::OOK_MODE_FIXED;
    rxcfg_host_inst.wr(8'h13, ~f);
    repeat (2) @(posedge clk);
    #1;
    chk(ook_threshold, ~f);
    @(posedge clk);
    continuous_mode <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      c = 3'($urandom_range(3));
      sync_case(2'(k / 2), c[1:0], int'(c) + k % 2, 1'b0);
    end
    sync_case(2'($urandom_range(3)), 2'h0, 0, 1'b1);
    // Cutoff 00 settles four times faster than cutoff 11
    @(posedge clk);
    ook_mode <= rxcfg_pkg::OOK_MODE_AVG;
    for (int k = 0; k < 2; k++) begin
      rxcfg_host_inst.wr(8'h15, {6'h00, {2{k[0]}}});
      @(posedge clk);
      rssi_meas <= 8'h00;
      repeat (400) @(posedge clk);
      rssi_meas <= 8'hC8;
      repeat (24) @(posedge clk);
      #1;
      chk({7'h00, ook_threshold >= 8'h88}, {7'h00, k == 0});
      repeat (400) @(posedge clk);
      #1;
      chk({7'h00, ook_threshold inside {8'hC7, 8'hC8}}, 8'h01);
    end
    print_verdict;
  end
endmodule // rx_sync_tx_config_regs_test

// ---- rxcfg_host.sv ----
`timescale 1ns/1ns
module rxcfg_host (
  input  wire logic       clk,
  input  wire logic [7:0] cfg_rdata,
  output logic      [7:0] cfg_addr,
  output logic            cfg_wr,
  output logic            cfg_rd,
  output logic      [7:0] cfg_wdata
);
  initial begin
    cfg_addr = 8'h00;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 8'h00;
  end
  // One register write, released with inverted address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h14) return;
    if (a == 8'h15 && d[1] != d[0]) d[1:0] = 2'h0;
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
    #1;
  endtask
  // One register read, data taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    #1;
    d = cfg_rdata;
  endtask
endmodule // rxcfg_host

// ---- rxcfg_monitor.sv ----
`timescale 1ns/1ns
module rxcfg_monitor (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] cfg_addr,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic       buffered_mode,
  input wire logic       fill_manual,
  input wire logic       sync_restart,
  input wire logic [7:0] rssi_meas,
  input wire logic       sync_match,
  input wire logic       sync_found,
  input wire logic       fifo_fill_start,
  input wire logic [3:0] tx_smoothing_cutoff,
  input wire logic [2:0] tx_power_step,
  input wire logic       tx_zero_if
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////
  sequence s_tx_wr;
    cfg_wr && cfg_addr == rxcfg_pkg::ADDR_TRANSMIT_SETTINGS;
  endsequence
  sequence s_restart;
    sync_found && sync_restart;
  endsequence
  property p_tx_write;
    s_tx_wr |=> {tx_smoothing_cutoff, tx_power_step, tx_zero_if} == $past(cfg_wdata);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx fields wrong");
  property p_tx_read;
    cfg_rd && !cfg_wr && cfg_addr == rxcfg_pkg::ADDR_TRANSMIT_SETTINGS
      |=> cfg_rdata == $past({tx_smoothing_cutoff, tx_power_step, tx_zero_if});
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("tx readback wrong");
  property p_strength;
    cfg_rd && cfg_addr == rxcfg_pkg::ADDR_SIGNAL_STRENGTH |=> cfg_rdata == $past(rssi_meas);
  endproperty
  a_strength: assert property (p_strength) else $error("strength read wrong");
  property p_match_found;
    sync_match |-> sync_found;
  endproperty
  a_match_found: assert property (p_match_found) else $error("match without found");
  property p_match_pulse;
    sync_match |=> !sync_match;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match too long");
  property p_restart;
    s_restart |=> !sync_found;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");
  property p_found_hold;
    sync_found && !sync_restart && !cfg_wr && !$past(cfg_wr) && !$past(cfg_wr, 2)
      |=> sync_found;
  endproperty
  a_found_hold: assert property (p_found_hold) else $error("found dropped");
  property p_fill;
    fifo_fill_start |-> sync_match && $past(buffered_mode) && !$past(fill_manual);
  endproperty
  a_fill: assert property (p_fill) else $error("fill start wrong");
endmodule // rxcfg_monitor
bind rxcfg_regs rxcfg_monitor rxcfg_monitor_inst (.clk, .reset_n, .cfg_addr, .cfg_wr,
  .cfg_rd, .cfg_wdata, .cfg_rdata, .buffered_mode, .fill_manual, .sync_restart, .rssi_meas,
  .sync_match, .sync_found, .fifo_fill_start, .tx_smoothing_cutoff, .tx_power_step,
  .tx_zero_if);

// ---- rxcfg_pkg.sv ----
// Notes on behaviour
// R1: In continuous receive mode the bit synchronizer runs when its disable bit is 0 and is bypassed when it is 1.
// R2: The sync pattern is searched for only while the sync enable bit is 1, which is off after reset.
// R3: Sync length codes 00, 01, 10 and 11 select 8, 16, 24 and 32 bits, 32 bits after reset.
// R4: Sync tolerance codes 00 to 11 accept 0 to 3 mismatched bits, zero after reset.
// R5: Four pattern bytes hold bits 31:24 down to 7:0, and only the top bytes covered by the length take part.
// R6: The floor threshold byte gives the fixed slicing level or the peak mode minimum, 0x04 after reset.
// R7: The signal strength byte is read only at half a decibel per count, and writes to it have no effect.
// R8: Decrement step codes 000 to 111 select 0.5, 1, 1.5, 2, 3, 4, 5 and 6 dB, 0.5 dB after reset.
// R9: Decrement rate codes 000 to 011 give one step per 1, 2, 4 or 8 chips, 100 to 111 give 2 to 16 per chip.
// R10: Average cutoff code 00 gives the slow bit rate over 8 pi filter and 11 the bit rate over 32 pi one; in the code 00 settles faster than 11.
// R11: The four bit smoothing cutoff field drives the transmit filter, 0111 after reset.
// R12: The three bit power field lowers output by one step per code from full power, 001 after reset.
// R13: The zero IF bit set to 1 selects zero first IF and turns off frequency deviation.
// R14: In buffered mode with automatic fill, filling starts as soon as the sync pattern matches.
// R15: A match is declared when the newest received bits differ from the top pattern bits in no more than tolerance bits.
// R16: Reset loads every writable field with its default before any access.
package rxcfg_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_RX_SYNC_CONTROL   = 8'h12;
  localparam logic [7:0] ADDR_OOK_FIXED_THRESH  = 8'h13;
  localparam logic [7:0] ADDR_SIGNAL_STRENGTH   = 8'h14;
  localparam logic [7:0] ADDR_ONOFF_FLOOR_THRESHOLD_ADAPT  = 8'h15;
  localparam logic [7:0] ADDR_SYNC_PATTERN_B1   = 8'h16;
  localparam logic [7:0] ADDR_SYNC_PATTERN_B2   = 8'h17;
  localparam logic [7:0] ADDR_SYNC_PATTERN_B3   = 8'h18;
  localparam logic [7:0] ADDR_SYNC_PATTERN_B4   = 8'h19;
  localparam logic [7:0] ADDR_TRANSMIT_SETTINGS = 8'h1A;

  // Field positions in rx_sync_control
  localparam int BITSYNC_OFF_POS = 6;
  localparam int SYNC_ON_POS     = 5;
  localparam int SYNC_SIZE_LSB   = 3;
  localparam int SYNC_TOL_LSB    = 1;

  // Field positions in ook_threshold_adapt
  localparam int DEC_STEP_LSB   = 5;
  localparam int DEC_RATE_LSB   = 2;
  localparam int AVG_CUTOFF_LSB = 0;

  // Field positions in transmit_settings
  localparam int TX_CUTOFF_LSB = 4;
  localparam int TX_POWER_LSB  = 1;
  localparam int TX_ZERO_IF_POS = 0;

  // Reset values
  localparam logic [7:0] RST_RX_SYNC_CONTROL   = 8'h18;
  localparam logic [7:0] RST_OOK_FIXED_THRESH  = 8'h04;
  localparam logic [7:0] RST_ONOFF_FLOOR_THRESHOLD_ADAPT  = 8'h00;
  localparam logic [7:0] RST_SYNC_PATTERN      = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_SETTINGS = 8'h72;

  // Threshold modes on the ook_mode input
  localparam logic [1:0] OOK_MODE_FIXED = 2'h0;
  localparam logic [1:0] OOK_MODE_PEAK  = 2'h1;
  localparam logic [1:0] OOK_MODE_AVG   = 2'h2;

  // Average cutoff codes and their filter shifts
  localparam logic [1:0] AVG_CUTOFF_SLOW = 2'h0;
  localparam logic [1:0] AVG_CUTOFF_FAST = 2'h3;
  localparam int AVG_SHIFT_SLOW = 3;
  localparam int AVG_SHIFT_FAST = 5;

  // Sync engine states, Gray coded
  typedef enum logic [1:0] {
    RXCFG_IDLE   = 2'b00,
    RXCFG_SEARCH = 2'b01,
    RXCFG_FOUND  = 2'b11
  } rxcfg_state_t;

endpackage

// ---- rxcfg_regs.sv ----
`timescale 1ns/1ns
module rxcfg_regs #(
  parameter int BIT_CYCLES  = 100,
  parameter int CHIP_CYCLES = 256
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] cfg_addr,
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  input  wire logic       rx_data_pin,
  input  wire logic       rx_strobe_raw,
  input  wire logic       continuous_mode,
  input  wire logic       buffered_mode,
  input  wire logic       fill_manual,
  input  wire logic       sync_restart,
  input  wire logic [7:0] rssi_meas,
  input  wire logic [1:0] ook_mode,
  output logic            rx_data_out,
  output logic            rx_data_strobe,
  output logic            sync_match,
  output logic            sync_found,
  output logic            fifo_fill_start,
  output logic      [7:0] ook_threshold,
  output logic      [3:0] tx_smoothing_cutoff,
  output logic      [2:0] tx_power_step,
  output logic            tx_zero_if,
  output logic            tx_deviation_en
);

  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
    $error("BIT_CYCLES out of range");
  end
  if (CHIP_CYCLES < 16 || CHIP_CYCLES > 65536 ||
      (CHIP_CYCLES & (CHIP_CYCLES - 1)) != 0) begin : g_bad_chip_cycles
    $error("CHIP_CYCLES must be a power of two from 16 to 65536");
  end

  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HALF  = 16'(BIT_CYCLES / 2);
  localparam logic [15:0] CHIP_MASK = 16'(CHIP_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [5:0] sync_len(input logic [1:0] code);
    sync_len = {1'b0, code, 3'b000} + 6'h08;
  endfunction

  function automatic logic [5:0] count_ones(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    count_ones = n;
  endfunction

  function automatic logic [7:0] step_half_db(input logic [2:0] code);
    unique case (code)
      3'h0: step_half_db = 8'h01;
      3'h1: step_half_db = 8'h02;
      3'h2: step_half_db = 8'h03;
      3'h3: step_half_db = 8'h04;
      3'h4: step_half_db = 8'h06;
      3'h5: step_half_db = 8'h08;
      3'h6: step_half_db = 8'h0A;
      3'h7: step_half_db = 8'h0C;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]               ctl;
    logic [7:0]               floor_thr;
    logic [7:0]               adapt;
    logic [7:0]               pat1;
    logic [7:0]               pat2;
    logic [7:0]               pat3;
    logic [7:0]               pat4;
    logic [7:0]               txs;
    logic [7:0]               rdata;
    logic                     pin_meta;
    logic                     pin_sync;
    logic                     pin_prev;
    logic [15:0]              bs_cnt;
    logic                     bit_val;
    logic                     bit_stb;
    logic                     dout;
    logic                     dstb;
    logic [31:0]              shift;
    logic [5:0]               nbits;
    rxcfg_pkg::rxcfg_state_t  state;
    logic                     match;
    logic                     fill_start;
    logic [15:0]              div_cnt;
    logic [2:0]               chip_cnt;
    logic [7:0]               thr;
    logic [15:0]              avg_acc;
  } rxcfg_regs_t;

  rxcfg_regs_t s_r;
  rxcfg_regs_t s_nxt;

  logic [31:0] pattern;
  logic [5:0]  len;
  logic [31:0] len_mask;
  logic [31:0] expect_bits;
  logic [31:0] shift_new;
  logic [1:0]  tol;
  logic        bypass;
  logic        new_bit;
  logic        new_stb;
  logic        hit;
  logic        chip_tick;
  logic        dec_tick;
  logic [2:0]  rate;
  logic [15:0] sub_mask;
  logic [2:0]  chip_mask;
  logic [8:0]  thr_low;
  logic [16:0] avg_diff;
  logic [16:0] avg_delta;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.match      = 1'b0;
    s_nxt.fill_start = 1'b0;
    s_nxt.bit_stb    = 1'b0;

    // Register writes; the strength byte takes no write
    if (cfg_wr) begin
      unique case (cfg_addr)
        rxcfg_pkg::ADDR_RX_SYNC_CONTROL:   s_nxt.ctl = cfg_wdata;
        rxcfg_pkg::ADDR_OOK_FIXED_THRESH:  s_nxt.floor_thr = cfg_wdata; // R6
        rxcfg_pkg::ADDR_ONOFF_FLOOR_THRESHOLD_ADAPT:  s_nxt.adapt = cfg_wdata;
        rxcfg_pkg::ADDR_SYNC_PATTERN_B1:   s_nxt.pat1 = cfg_wdata;
        rxcfg_pkg::ADDR_SYNC_PATTERN_B2:   s_nxt.pat2 = cfg_wdata;
        rxcfg_pkg::ADDR_SYNC_PATTERN_B3:   s_nxt.pat3 = cfg_wdata;
        rxcfg_pkg::ADDR_SYNC_PATTERN_B4:   s_nxt.pat4 = cfg_wdata;
        rxcfg_pkg::ADDR_TRANSMIT_SETTINGS: s_nxt.txs = cfg_wdata;
        default: ;
      endcase
    end

    // Register reads, answered one cycle after the strobe
    if (cfg_rd) begin
      unique case (cfg_addr)
        rxcfg_pkg::ADDR_RX_SYNC_CONTROL:   s_nxt.rdata = s_r.ctl;
        rxcfg_pkg::ADDR_OOK_FIXED_THRESH:  s_nxt.rdata = s_r.floor_thr;
        rxcfg_pkg::ADDR_SIGNAL_STRENGTH:   s_nxt.rdata = rssi_meas; // R7
        rxcfg_pkg::ADDR_ONOFF_FLOOR_THRESHOLD_ADAPT:  s_nxt.rdata = s_r.adapt;
        rxcfg_pkg::ADDR_SYNC_PATTERN_B1:   s_nxt.rdata = s_r.pat1;
        rxcfg_pkg::ADDR_SYNC_PATTERN_B2:   s_nxt.rdata = s_r.pat2;
        rxcfg_pkg::ADDR_SYNC_PATTERN_B3:   s_nxt.rdata = s_r.pat3;
        rxcfg_pkg::ADDR_SYNC_PATTERN_B4:   s_nxt.rdata = s_r.pat4;
        rxcfg_pkg::ADDR_TRANSMIT_SETTINGS: s_nxt.rdata = s_r.txs;
        default:                           s_nxt.rdata = 8'h00;
      endcase
    end

    // Data pin synchroniser
    s_nxt.pin_meta = rx_data_pin;
    s_nxt.pin_sync = s_r.pin_meta;
    s_nxt.pin_prev = s_r.pin_sync;

    // Bit synchroniser: realign on each edge, sample mid bit
    if (s_r.pin_sync != s_r.pin_prev) begin
      s_nxt.bs_cnt = BIT_HALF;
    end else if (s_r.bs_cnt == 16'h0000) begin
      s_nxt.bs_cnt  = BIT_LAST;
      s_nxt.bit_val = s_r.pin_sync;
      s_nxt.bit_stb = 1'b1;
    end else begin
      s_nxt.bs_cnt = s_r.bs_cnt - 16'h0001;
    end

    // Selected bit source
    bypass  = continuous_mode && s_r.ctl[rxcfg_pkg::BITSYNC_OFF_POS]; // R1
    new_bit = bypass ? s_r.pin_sync : s_r.bit_val; // R1
    new_stb = bypass ? rx_strobe_raw : s_r.bit_stb; // R1
    s_nxt.dout = new_bit; // R1
    s_nxt.dstb = new_stb; // R1

    // Pattern compare
    pattern     = {s_r.pat1, s_r.pat2, s_r.pat3, s_r.pat4}; // R5
    len         = sync_len(s_r.ctl[rxcfg_pkg::SYNC_SIZE_LSB +: 2]); // R3
    len_mask    = 32'hFFFFFFFF >> (6'd32 - len); // R5
    expect_bits = pattern >> (6'd32 - len); // R15
    tol         = s_r.ctl[rxcfg_pkg::SYNC_TOL_LSB +: 2]; // R4
    shift_new   = {s_r.shift[30:0], new_bit};
    hit = (s_r.nbits >= len - 6'h01)
       && (count_ones((shift_new ^ expect_bits) & len_mask) <= {4'h0, tol}); // R15 R4

    // Sync engine
    unique case (s_r.state)
      rxcfg_pkg::RXCFG_IDLE: begin
        s_nxt.nbits = 6'h00;
        if (s_r.ctl[rxcfg_pkg::SYNC_ON_POS]) begin
          s_nxt.state = rxcfg_pkg::RXCFG_SEARCH; // R2
        end
      end
      rxcfg_pkg::RXCFG_SEARCH: begin
        if (!s_r.ctl[rxcfg_pkg::SYNC_ON_POS]) begin
          s_nxt.state = rxcfg_pkg::RXCFG_IDLE; // R2
        end else if (new_stb) begin
          s_nxt.shift = shift_new;
          if (s_r.nbits != 6'h20) begin
            s_nxt.nbits = s_r.nbits + 6'h01;
          end
          if (hit) begin
            s_nxt.state = rxcfg_pkg::RXCFG_FOUND;
            s_nxt.match = 1'b1;
            s_nxt.fill_start = buffered_mode && !fill_manual; // R14
          end
        end
      end
      rxcfg_pkg::RXCFG_FOUND: begin
        if (!s_r.ctl[rxcfg_pkg::SYNC_ON_POS]) begin
          s_nxt.state = rxcfg_pkg::RXCFG_IDLE; // R2
        end else if (sync_restart) begin
          s_nxt.state = rxcfg_pkg::RXCFG_SEARCH;
          s_nxt.nbits = 6'h00;
        end
      end
      default: s_nxt.state = rxcfg_pkg::RXCFG_IDLE;
    endcase

    // Chip divider and decrement ticks
    s_nxt.div_cnt = (s_r.div_cnt + 16'h0001) & CHIP_MASK;
    chip_tick = (s_r.div_cnt == 16'h0000);
    if (chip_tick) begin
      s_nxt.chip_cnt = s_r.chip_cnt + 3'h1;
    end
    rate = s_r.adapt[rxcfg_pkg::DEC_RATE_LSB +: 3];
    sub_mask  = CHIP_MASK >> (3'(rate[1:0]) + 3'h1); // R9
    chip_mask = 3'h7 >> (2'h3 - rate[1:0]); // R9
    if (rate[2]) begin
      dec_tick = ((s_r.div_cnt & sub_mask) == 16'h0000); // R9
    end else begin
      dec_tick = chip_tick && ((s_r.chip_cnt & chip_mask) == 3'h0); // R9
    end

    // Slicing threshold
    thr_low  = {1'b0, s_r.thr} - {1'b0, step_half_db(s_r.adapt[rxcfg_pkg::DEC_STEP_LSB +: 3])};
    avg_diff = {1'b0, rssi_meas, 8'h00} - {1'b0, s_r.avg_acc};
    if (s_r.adapt[rxcfg_pkg::AVG_CUTOFF_LSB +: 2] == rxcfg_pkg::AVG_CUTOFF_FAST) begin
      avg_delta = 17'($signed(avg_diff) >>> rxcfg_pkg::AVG_SHIFT_FAST); // R10
    end else begin
      avg_delta = 17'($signed(avg_diff) >>> rxcfg_pkg::AVG_SHIFT_SLOW); // R10
    end
    s_nxt.avg_acc = 16'({1'b0, s_r.avg_acc} + avg_delta);
    unique case (ook_mode)
      rxcfg_pkg::OOK_MODE_PEAK: begin
        if (rssi_meas > s_r.thr) begin
          s_nxt.thr = rssi_meas;
        end else if (dec_tick) begin
          if (thr_low[8] || thr_low[7:0] < s_r.floor_thr) begin
            s_nxt.thr = s_r.floor_thr; // R6
          end else begin
            s_nxt.thr = thr_low[7:0]; // R8
          end
        end
      end
      rxcfg_pkg::OOK_MODE_AVG: s_nxt.thr = s_r.avg_acc[15:8]; // R10
      default:                 s_nxt.thr = s_r.floor_thr; // R6
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r           <= '0;
      s_r.ctl       <= rxcfg_pkg::RST_RX_SYNC_CONTROL; // R16
      s_r.floor_thr <= rxcfg_pkg::RST_OOK_FIXED_THRESH; // R16
      s_r.adapt     <= rxcfg_pkg::RST_ONOFF_FLOOR_THRESHOLD_ADAPT; // R16
      s_r.pat1      <= rxcfg_pkg::RST_SYNC_PATTERN; // R16
      s_r.pat2      <= rxcfg_pkg::RST_SYNC_PATTERN; // R16
      s_r.pat3      <= rxcfg_pkg::RST_SYNC_PATTERN; // R16
      s_r.pat4      <= rxcfg_pkg::RST_SYNC_PATTERN; // R16
      s_r.txs       <= rxcfg_pkg::RST_TRANSMIT_SETTINGS; // R16
      s_r.thr       <= rxcfg_pkg::RST_OOK_FIXED_THRESH;
      s_r.state     <= rxcfg_pkg::RXCFG_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cfg_rdata           = s_r.rdata;
  assign rx_data_out         = s_r.dout; // R1
  assign rx_data_strobe      = s_r.dstb;
  assign sync_match          = s_r.match;
  assign sync_found          = (s_r.state == rxcfg_pkg::RXCFG_FOUND);
  assign fifo_fill_start     = s_r.fill_start; // R14
  assign ook_threshold       = s_r.thr;
  assign tx_smoothing_cutoff = s_r.txs[rxcfg_pkg::TX_CUTOFF_LSB +: 4]; // R11
  assign tx_power_step       = s_r.txs[rxcfg_pkg::TX_POWER_LSB +: 3]; // R12
  assign tx_zero_if          = s_r.txs[rxcfg_pkg::TX_ZERO_IF_POS]; // R13
  assign tx_deviation_en     = !s_r.txs[rxcfg_pkg::TX_ZERO_IF_POS]; // R13

endmodule // rxcfg_regs
